// ### rtl/sfa_pkg.sv
// Shared constants for the serial flash command framing block.
// Assumes both ends run on one 20 MHz system clock.
`default_nettype none
package sfa_pkg;
  localparam int unsigned CLK_MHZ            = 20;
  localparam int unsigned SELECT_DELAY_MS    = 1;   // power_to_select_delay
  localparam int unsigned WRITE_DELAY_MS     = 20;  // power_to_write_delay
  localparam int unsigned SELECT_DELAY_CYC   = SELECT_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned WRITE_DELAY_CYC    = WRITE_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned SCK_HALF_CYC       = 4;   // Host clock divider half period
  localparam int unsigned ADDR_BYTES         = 3;
  localparam int unsigned PAGE_LSB           = 9;
  localparam int unsigned PAGE_W             = 9;
  localparam int unsigned OFS_W              = 9;
  localparam int unsigned PAGE_HI_LSB        = 4;
  // Opcodes
  localparam logic [7:0] OP_RD_PAGE   = 8'h03;
  localparam logic [7:0] OP_RD_FAST   = 8'h0B;
  localparam logic [7:0] OP_BLK_ERASE = 8'h50;
  localparam logic [7:0] OP_XFER      = 8'h53;
  localparam logic [7:0] OP_REWRITE   = 8'h58;
  localparam logic [7:0] OP_COMPARE   = 8'h60;
  localparam logic [7:0] OP_SEC_RD    = 8'h77;
  localparam logic [7:0] OP_CHIP_ER   = 8'h7C;
  localparam logic [7:0] OP_PG_ERASE  = 8'h81;
  localparam logic [7:0] OP_PROG_BUF  = 8'h82;
  localparam logic [7:0] OP_PROG_ERS  = 8'h83;
  localparam logic [7:0] OP_BUF_WR    = 8'h84;
  localparam logic [7:0] OP_PROG_NOE  = 8'h88;
  localparam logic [7:0] OP_ID_RD     = 8'h9F;
  localparam logic [7:0] OP_DEEP_PD   = 8'hB9;
  localparam logic [7:0] OP_RESUME    = 8'hAB;
  localparam logic [7:0] OP_BUF_RD_LO = 8'hD1;
  localparam logic [7:0] OP_RD_LEGACY = 8'hD2;
  localparam logic [7:0] OP_BUF_RD    = 8'hD4;
  localparam logic [7:0] OP_STAT_RD   = 8'hD7;
  localparam logic [7:0] OP_CONT_RD   = 8'hE8;
  // Address usage classes
  typedef enum logic [2:0] {
    USE_NONE    = 3'h0,
    USE_FULL    = 3'h1,
    USE_PAGE    = 3'h2,
    USE_PAGE_HI = 3'h3,
    USE_OFS     = 3'h4,
    USE_IGNORE  = 3'h5,
    USE_UNKNOWN = 3'h6
  } sfa_use_type;
  // Address usage of an opcode
  function automatic sfa_use_type sfa_use(input logic [7:0] op);
    case (op)
      OP_RD_PAGE, OP_RD_FAST, OP_PROG_BUF, OP_RD_LEGACY, OP_CONT_RD: sfa_use = USE_FULL;
      OP_XFER, OP_REWRITE, OP_COMPARE, OP_PG_ERASE, OP_PROG_ERS, OP_PROG_NOE:
        sfa_use = USE_PAGE;
      OP_BLK_ERASE: sfa_use = USE_PAGE_HI;
      OP_BUF_WR, OP_BUF_RD_LO, OP_BUF_RD: sfa_use = USE_OFS;
      OP_SEC_RD, OP_CHIP_ER: sfa_use = USE_IGNORE;
      OP_ID_RD, OP_DEEP_PD, OP_RESUME, OP_STAT_RD: sfa_use = USE_NONE;
      default: sfa_use = USE_UNKNOWN;
    endcase
  endfunction
  // Dummy bytes after the address
  function automatic logic [2:0] sfa_dummies(input logic [7:0] op);
    case (op)
      OP_RD_FAST, OP_BUF_RD: sfa_dummies = 3'h1;
      OP_RD_LEGACY, OP_CONT_RD: sfa_dummies = 3'h4;
      default: sfa_dummies = 3'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### rtl/sfa_link_if.sv
// Serial link between host controller and flash framing end.
// Output pin of the flash is modelled as data plus active-low enable.
`default_nettype none
interface sfa_link_if;
  logic cs_n;      // Chip select, active low
  logic sck;       // Serial clock from host
  logic si;        // Host to flash data
  logic so;        // Flash to host data
  logic so_oe_n;   // Low while flash drives so
  modport host  (output cs_n, output sck, output si, input so, input so_oe_n);
  modport flash (input cs_n, input sck, input si, output so, output so_oe_n);
endinterface
`default_nettype wire

// ### rtl/sfa_flash_end.sv
// Flash side command framer: opcode, address split, dummy bytes, power-up.
// Assumes link pins are asynchronous to clock; resetn stands for internal POR.
//
// Contract
// - Three address bytes: 6 reserved, page, offset
// - Page-only opcodes ignore offset; 50h uses page top
// - Buffer opcodes ignore page; 77h,7Ch ignore all
// - Dummy bytes 1 or 4; some opcodes unaddressed
// - Default clock mode 3 after reset
// - Output high impedance after reset
// - Chip select fall required before decoding
// - Sample idle clock at select fall for mode
// - Ignore everything during power-on reset
// - Host waits 1 ms before select
// - Host waits 20 ms before writes
// - Enter standby, not deep power-down
// - 53h copy, 60h compare, 58h rewrite
// - ABh resumes, B9h enters deep power-down
`default_nettype none
module sfa_flash_end
  import sfa_pkg::*;
(
  input  wire logic              clock,        // System clock
  input  wire logic              resetn,       // Sync reset, power-on reset
  input  wire logic              clk_en,       // Freezes all state when low
  sfa_link_if.flash              link,         // Serial link
  output logic                   cmd_valid,    // Command framed, one pulse
  output logic [7:0]             cmd_op,       // Opcode
  output logic [PAGE_W-1:0]      cmd_page,     // Page field used
  output logic [OFS_W-1:0]       cmd_ofs,      // Offset field used
  output logic                   cmd_mode3,    // Mode of this transaction
  output logic                   deep_pd,      // In deep power-down
  output logic [1:0]             buf_action    // 1 copy, 2 compare, 3 rewrite
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_OP    = 2'h1,
    ST_ADDR  = 2'h2,
    ST_DUMMY = 2'h3
  } sfa_fst_type;

  // Two-stage synchronisers for pins
  logic [2:0] s1_ff, s2_ff;
  logic cs_d_ff, sck_d_ff;
  always_ff @(posedge clock)
    if (!resetn)
    begin
      // Keep tracking pins in reset: a select held low through reset is no fall
      s1_ff    <= {link.cs_n, link.sck, link.si};
      s2_ff    <= s1_ff;
      cs_d_ff  <= s2_ff[2];
      sck_d_ff <= s2_ff[1];
    end
    else if (clk_en)
    begin
      s1_ff    <= {link.cs_n, link.sck, link.si};
      s2_ff    <= s1_ff;
      cs_d_ff  <= s2_ff[2];
      sck_d_ff <= s2_ff[1];
    end

  wire cs_n_s  = s2_ff[2];
  wire sck_s   = s2_ff[1];
  wire si_s    = s2_ff[0];
  wire cs_fall = cs_d_ff && !cs_n_s;
  wire sck_r   = !sck_d_ff && sck_s;                 // Sample edge, modes 0 and 3

  sfa_fst_type st_ff, nxt_st;
  logic [7:0]  sh_ff;
  logic [2:0]  bit_ff;
  logic [2:0]  byte_ff;
  logic [7:0]  op_ff;
  logic [23:0] addr_ff;
  logic        mode3_ff;
  logic        dpd_ff;
  logic        valid_ff;
  logic [1:0]  act_ff;
  logic [PAGE_W-1:0] page_ff;
  logic [OFS_W-1:0]  ofs_ff;

  wire [7:0]   byte_in  = {sh_ff[6:0], si_s};         // MSB first
  wire         byte_end = sck_r && bit_ff == 3'h7;
  wire [23:0]  addr_in  = {addr_ff[15:0], byte_in};
  sfa_use_type use_w;
  assign use_w = sfa_use(op_ff);
  wire [2:0]   dum_w    = sfa_dummies(op_ff);
  wire [PAGE_W-1:0] pg_w = addr_in[PAGE_LSB +: PAGE_W];   // Reserved top 6 dropped
  wire [OFS_W-1:0]  of_w = addr_in[OFS_W-1:0];
  wire op_addr = sfa_use(byte_in) != USE_NONE && sfa_use(byte_in) != USE_UNKNOWN;
  wire finish_addr = st_ff == ST_ADDR && byte_end && byte_ff == 3'(ADDR_BYTES - 1);
  wire finish_dum  = st_ff == ST_DUMMY && byte_end && byte_ff == dum_w - 3'h1;
  wire finish_op   = st_ff == ST_OP && byte_end && sfa_use(byte_in) == USE_NONE;
  // Deep power-down only listens for resume
  wire op_ok = !dpd_ff || byte_in == OP_RESUME;

  // Next state of the framer
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:  if (cs_fall) nxt_st = ST_OP;
      ST_OP:    if (byte_end) nxt_st = (op_addr && op_ok) ? ST_ADDR : ST_IDLE;
      ST_ADDR:  if (finish_addr) nxt_st = (dum_w != 3'h0) ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: if (finish_dum) nxt_st = ST_IDLE;
      default:  nxt_st = ST_IDLE;
    endcase
    if (cs_n_s) nxt_st = ST_IDLE;                     // Deselect aborts frame
  end

  // Shift, count and capture; reset forces idle and ignores commands
  always_ff @(posedge clock)
    if (!resetn)
    begin
      st_ff <= ST_IDLE;
      sh_ff <= 8'h00;
      bit_ff <= 3'h0;
      byte_ff <= 3'h0;
      op_ff <= 8'h00;
      addr_ff <= 24'h000000;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
      if (st_ff == ST_IDLE || cs_n_s)
      begin
        bit_ff  <= 3'h0;
        byte_ff <= 3'h0;
      end
      else if (sck_r)
      begin
        sh_ff  <= byte_in;
        bit_ff <= bit_ff + 3'h1;
        if (byte_end && st_ff != ST_OP && !finish_addr)
          byte_ff <= byte_ff + 3'h1;
        else if (finish_addr)
          byte_ff <= 3'h0;
        if (byte_end && st_ff == ST_OP)
          op_ff <= byte_in;
        if (byte_end && st_ff == ST_ADDR)
          addr_ff <= addr_in;
      end
    end

  // Mode capture, power state and command report
  always_ff @(posedge clock)
    if (!resetn)
    begin
      mode3_ff <= 1'h1;
      dpd_ff   <= 1'h0;                               // Standby after power-up
      valid_ff <= 1'h0;
      act_ff   <= 2'h0;
      page_ff  <= '0;
      ofs_ff   <= '0;
    end
    else if (clk_en)
    begin
      valid_ff <= 1'h0;
      if (cs_fall)
        mode3_ff <= sck_s;                            // Idle level picks mode
      if (finish_op && op_ok)
      begin
        valid_ff <= 1'h1;
        page_ff  <= '0;
        ofs_ff   <= '0;
        act_ff   <= 2'h0;
        if (byte_in == OP_DEEP_PD) dpd_ff <= 1'h1;
        if (byte_in == OP_RESUME)  dpd_ff <= 1'h0;
      end
      if (finish_addr)
      begin
        valid_ff <= 1'h1;
        page_ff  <= (use_w == USE_FULL || use_w == USE_PAGE) ? pg_w :
                    (use_w == USE_PAGE_HI) ? {pg_w[PAGE_W-1:PAGE_HI_LSB], 4'h0} : '0;
        ofs_ff   <= (use_w == USE_FULL || use_w == USE_OFS) ? of_w : '0;
        act_ff   <= (op_ff == OP_XFER) ? 2'h1 :
                    (op_ff == OP_COMPARE) ? 2'h2 :
                    (op_ff == OP_REWRITE) ? 2'h3 : 2'h0;
      end
    end

  assign cmd_valid  = valid_ff;
  assign cmd_op     = op_ff;
  assign cmd_page   = page_ff;
  assign cmd_ofs    = ofs_ff;
  assign cmd_mode3  = mode3_ff;
  assign deep_pd    = dpd_ff;
  assign buf_action = act_ff;
  // Framing only: no read data, so the output stays released
  assign link.so      = 1'h0;
  assign link.so_oe_n = 1'h1;
endmodule
`default_nettype wire

// ### rtl/sfa_host_end.sv
// Host controller: frames opcode, address and dummy bytes on the link.
// Assumes user requests are on clock; makes the serial clock by a divider.
`default_nettype none
module sfa_host_end
  import sfa_pkg::*;
#(
  parameter int unsigned SEL_CYC = SELECT_DELAY_CYC,  // Delay before first select
  parameter int unsigned WR_CYC  = WRITE_DELAY_CYC    // Delay before program/erase
)(
  input  wire logic              clock,      // System clock
  input  wire logic              resetn,     // Sync reset, active low
  input  wire logic              clk_en,     // Freezes all state when low
  input  wire logic              req,        // Start a command, level held until ack
  input  wire logic [7:0]        req_op,     // Opcode
  input  wire logic [PAGE_W-1:0] req_page,   // Page number
  input  wire logic [OFS_W-1:0]  req_ofs,    // Byte offset
  output logic                   ack,        // Command sent, one pulse
  output logic                   ready,      // Idle and select delay met
  sfa_link_if.host               link        // Serial link
);
  localparam int CW = 32;
  logic [CW-1:0] pwr_ff;
  logic          busy_ff, cs_n_ff, sck_ff, ack_ff;
  logic          first_ff;   // No fall yet in this frame, keep the MSB
  logic [63:0]   sh_ff;
  logic [6:0]    bits_ff;
  logic [3:0]    div_ff;

  wire is_write = req_op == OP_BLK_ERASE || req_op == OP_CHIP_ER || req_op == OP_PG_ERASE
               || req_op == OP_PROG_BUF || req_op == OP_PROG_ERS || req_op == OP_PROG_NOE
               || req_op == OP_REWRITE;
  wire sel_ok = pwr_ff >= CW'(SEL_CYC);
  wire wr_ok  = pwr_ff >= CW'(WR_CYC);
  wire go     = req && !busy_ff && !ack_ff && sel_ok && (!is_write || wr_ok);
  wire addr_n = sfa_use(req_op) != USE_NONE;
  wire [6:0] nbits = 7'(8 + (addr_n ? 24 : 0) + 8 * sfa_dummies(req_op));
  wire [23:0] addr = {6'h00, req_page, req_ofs};
  wire half = div_ff == 4'(SCK_HALF_CYC - 1);

  // Power-up timer saturates
  always_ff @(posedge clock)
    if (!resetn)
      pwr_ff <= '0;
    else if (clk_en && !wr_ok)
      pwr_ff <= pwr_ff + 1'b1;

  // Mode 3 shifter: change on falling, flash samples on rising, MSB first
  always_ff @(posedge clock)
    if (!resetn)
    begin
      busy_ff <= 1'h0; cs_n_ff <= 1'h1; sck_ff <= 1'h1; ack_ff <= 1'h0;
      sh_ff <= '0; bits_ff <= '0; div_ff <= '0;
      first_ff <= 1'h0;
    end
    else if (clk_en)
    begin
      ack_ff <= 1'h0;
      if (go)
      begin
        busy_ff <= 1'h1; cs_n_ff <= 1'h0; div_ff <= '0;    // Falling select
        first_ff <= 1'h1;
        sh_ff <= {req_op, addr, 32'h0} & ~(64'h0);
        if (!addr_n) sh_ff <= {req_op, 56'h0};
        bits_ff <= nbits;
      end
      else if (busy_ff)
      begin
        div_ff <= half ? 4'h0 : div_ff + 4'h1;
        if (half)
        begin
          if (bits_ff == 7'h0)
          begin
            busy_ff <= 1'h0; cs_n_ff <= 1'h1; sck_ff <= 1'h1; ack_ff <= 1'h1;
          end
          else if (sck_ff)
          begin
            // Shift on the fall so data is steady at the flash's rise
            sck_ff <= 1'h0;
            if (!first_ff)
              sh_ff <= {sh_ff[62:0], 1'h0};
          end
          else
          begin
            sck_ff <= 1'h1;
            first_ff <= 1'h0;
            bits_ff <= bits_ff - 7'h1;
          end
        end
      end
    end

  reg rdy_ff;
  always_ff @(posedge clock)
    if (!resetn) rdy_ff <= 1'h0;
    else if (clk_en) rdy_ff <= sel_ok && !busy_ff && !go;

  assign ack       = ack_ff;
  assign ready     = rdy_ff;
  assign link.cs_n = cs_n_ff;
  assign link.sck  = sck_ff;
  assign link.si   = sh_ff[63];
endmodule
`default_nettype wire

// ### verif/sfa_link_monitor.sv
// Wire checker for the serial link joining the host and flash ends.
// Assumes one system clock samples every link signal.
`default_nettype none
module sfa_link_monitor #(
  parameter int unsigned SEL_CYC = 50  // Host delay before first select
)(
  input wire logic clock,    // System clock
  input wire logic resetn,   // Sync reset, active low
  input wire logic cs_n,     // Chip select
  input wire logic sck,      // Serial clock
  input wire logic si,       // Host data
  input wire logic so,       // Flash data
  input wire logic so_oe_n   // Flash output enable, low drives
);
  logic [31:0] cyc_ff;
  logic [6:0]  rise_ff;
  logic        sck_ff;
  // Cycles since reset, saturating at SEL_CYC, and sck rises per frame
  always_ff @(posedge clock)
  begin
    cyc_ff <= !resetn ? 32'h0 : (cyc_ff < SEL_CYC ? cyc_ff + 32'h1 : cyc_ff);
    sck_ff <= sck;
    rise_ff <= cs_n ? 7'h00 : rise_ff + {6'h00, sck & ~sck_ff};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  rel_so_a: assert property (so_oe_n)
    else $error("flash output driven");
  idle_high_a: assert property (cs_n |-> sck)
    else $error("serial clock not high while deselected");
  sel_hold_a: assert property ($fell(cs_n) |-> (!cs_n) [*8])
    else $error("select too short");
  si_edge_a: assert property (!cs_n && $past(!cs_n) && $changed(si) |-> !sck)
    else $error("host data moved while clock high");
  sck_high_a: assert property ($rose(sck) |-> sck [*4])
    else $error("clock high phase wrong");
  sck_low_a: assert property ($fell(sck) |-> (!sck) [*4])
    else $error("clock low phase wrong");
  frame_bits_a: assert property ($rose(cs_n) |-> rise_ff inside {7'h08, 7'h20, 7'h28, 7'h40})
    else $error("frame bit count wrong");
  sel_delay_a: assert property (!cs_n |-> cyc_ff >= SEL_CYC - 1)
    else $error("select before power-up delay");
  cover property ($rose(cs_n) && rise_ff == 7'h40);
  cover property ($rose(cs_n) && rise_ff == 7'h08);
  cover property ($rose(cs_n) && rise_ff == 7'h28);
endmodule
`default_nettype wire

// ### verif/serial_flash_addr_frame_powerup_test.sv
// Bench: host end drives flash end; a second flash end is bit-banged.
// Assumes shortened power-up delays and a 400 ns hand-made link clock.
`default_nettype none
module serial_flash_addr_frame_powerup_test import sfa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SEL = 50;
  localparam int unsigned WR  = 100;
  localparam logic [8:0]  P   = 9'h15A;
  localparam logic [8:0]  O   = 9'h0C3;
  localparam logic [8:0]  Z   = 9'h000;
  localparam logic [23:0] ADR = {6'h3F, 9'h101, 9'h0FE};
  typedef struct packed
  {
    logic [7:0] op;
    logic [8:0] pg;
    logic [8:0] of;
    logic [1:0] act;
    logic       dpd;
  } sfa_row_type;
  logic        clock, resetn, req, ack, ready, cmd_valid, cmd_mode3, deep_pd, b_valid, b_mode3;
  logic [7:0]  req_op, cmd_op, b_op;
  logic [8:0]  cmd_page, cmd_ofs, b_page, b_ofs;
  logic [1:0]  buf_action;
  int          fail_count, tests_run, vcnt, bcnt, n, nv, cyc, sel_at;
  sfa_row_type rows [20];
  sfa_link_if link ();
  sfa_link_if link_b ();
  sfa_host_end #(.SEL_CYC(SEL), .WR_CYC(WR)) sfa_host_end_inst (.clock, .resetn,
    .clk_en(1'b1), .req, .req_op, .req_page(P), .req_ofs(O), .ack, .ready, .link(link));
  sfa_flash_end sfa_flash_end_inst (.clock, .resetn, .clk_en(1'b1), .link(link), .cmd_valid,
    .cmd_op, .cmd_page, .cmd_ofs, .cmd_mode3, .deep_pd, .buf_action);
  sfa_flash_end sfa_flash_end_inst_b (.clock, .resetn, .clk_en(1'b1), .link(link_b),
    .cmd_valid(b_valid), .cmd_op(b_op), .cmd_page(b_page), .cmd_ofs(b_ofs),
    .cmd_mode3(b_mode3), .deep_pd(), .buf_action());
  sfa_link_monitor #(.SEL_CYC(SEL)) sfa_link_monitor_inst (.clock, .resetn, .cs_n(link.cs_n),
    .sck(link.sck), .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n));
  // 50 ns clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Pulse counters and first select after reset
  always @(posedge clock)
  begin
    vcnt = vcnt + (cmd_valid === 1'b1);
    bcnt = bcnt + (b_valid === 1'b1);
    cyc = resetn ? cyc + 1 : 0;
    if (!resetn)
      sel_at = 0;
    else if (link.cs_n === 1'b0 && sel_at == 0)
      sel_at = cyc;
  end
  task step(input int k);
    repeat (k) @(posedge clock);
  endtask
  task chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  // Request held until ack is sampled high, then dropped on that edge
  task send(input logic [7:0] op, output int cnt);
    int k;
    @(posedge clock);
    k = vcnt;
    req <= 1'b1;
    req_op <= op;
    n = 0;
    @(posedge clock);
    while (ack !== 1'b1 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    req <= 1'b0;
    step(30);
    @(negedge clock);
    cnt = vcnt - k;
    chk("ack", 9'h1, {8'h00, n < 3000});
  endtask
  // Mode 0 byte, MSB first: data set while low, taken on the rise
  task bang(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      link_b.si <= b[i];
      step(4);
      link_b.sck <= 1'b1;
      step(4);
      link_b.sck <= 1'b0;
    end
  endtask
  task wrap_up;
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Cut a hang short
  initial
  begin
    #3000000;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    rows = '{'{8'h03, P, O, 2'h0, 1'h0}, '{8'h0B, P, O, 2'h0, 1'h0}, '{8'h50, 9'h150, Z, 2'h0, 1'h0},
      '{8'h53, P, Z, 2'h1, 1'h0}, '{8'h58, P, Z, 2'h3, 1'h0}, '{8'h60, P, Z, 2'h2, 1'h0},
      '{8'h77, Z, Z, 2'h0, 1'h0}, '{8'h7C, Z, Z, 2'h0, 1'h0}, '{8'h81, P, Z, 2'h0, 1'h0},
      '{8'h82, P, O, 2'h0, 1'h0}, '{8'h83, P, Z, 2'h0, 1'h0}, '{8'h84, Z, O, 2'h0, 1'h0},
      '{8'h88, P, Z, 2'h0, 1'h0}, '{8'h9F, Z, Z, 2'h0, 1'h0}, '{8'hD1, Z, O, 2'h0, 1'h0},
      '{8'hD2, P, O, 2'h0, 1'h0}, '{8'hD4, Z, O, 2'h0, 1'h0}, '{8'hD7, Z, Z, 2'h0, 1'h0},
      '{8'hE8, P, O, 2'h0, 1'h0}, '{8'hB9, Z, Z, 2'h0, 1'h1}};
    {resetn, req, req_op, link_b.cs_n, link_b.sck, link_b.si} = '0;
    {fail_count, tests_run, vcnt, bcnt, cyc, sel_at} = '0;
    step(16);
    resetn <= 1'b1;
    @(negedge clock);
    chk("mode3", 9'h1, {8'h00, cmd_mode3});
    chk("deep_pd", Z, {8'h00, deep_pd});
    chk("so_oe_n", 9'h1, {8'h00, link_b.so_oe_n});
    n = 0;
    while (ready !== 1'b1 && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
    chk("ready_wait", 9'h1, {8'h00, n >= SEL - 2});
    // Select low since time zero: no fall, so nothing framed
    bang(8'h9F);
    step(20);
    chk("no_fall", Z, bcnt[8:0]);
    link_b.cs_n <= 1'b1;
    step(4);
    link_b.cs_n <= 1'b0;
    step(4);
    bang(8'h03);
    bang(ADR[23:16]);
    bang(ADR[15:8]);
    bang(ADR[7:0]);
    step(4);
    link_b.cs_n <= 1'b1;
    step(20);
    chk("b_count", 9'h1, bcnt[8:0]);
    chk("b_mode3", Z, {8'h00, b_mode3});
    chk("b_op", 9'h003, {1'b0, b_op});
    chk("b_page", 9'h101, b_page);
    chk("b_ofs", 9'h0FE, b_ofs);
    foreach (rows[i])
    begin
      send(rows[i].op, nv);
      chk("count", 9'h1, nv[8:0]);
      chk("op", {1'b0, rows[i].op}, {1'b0, cmd_op});
      chk("page", rows[i].pg, cmd_page);
      chk("ofs", rows[i].of, cmd_ofs);
      chk("mode3", 9'h1, {8'h00, cmd_mode3});
      chk("deep_pd", {8'h00, rows[i].dpd}, {8'h00, deep_pd});
      if (rows[i].act != 2'h0)
        chk("action", {7'h00, rows[i].act}, {7'h00, buf_action});
    end
    send(8'h03, nv);
    chk("pd_ignored", Z, nv[8:0]);
    send(8'hAB, nv);
    chk("resume", Z, {8'h00, deep_pd});
    send(8'hB9, nv);
    // Reset in deep power-down, with a whole framed byte inside it
    @(posedge clock);
    resetn <= 1'b0;
    nv = bcnt;
    link_b.cs_n <= 1'b1;
    step(4);
    link_b.cs_n <= 1'b0;
    step(4);
    bang(8'h9F);
    step(4);
    chk("por_ignored", Z, 9'(bcnt - nv));
    resetn <= 1'b1;
    send(8'h82, nv);
    chk("write_wait", 9'h1, {8'h00, sel_at >= WR - 1});
    chk("standby", Z, {8'h00, deep_pd});
    wrap_up();
  end
endmodule
`default_nettype wire
